// >>> logic/rtca_params.svh
// Constants of the clock control and alarm weekday block
// Assumes inclusion by bare name from the design file
`ifndef RTCA_PARAMS_SVH
`define RTCA_PARAMS_SVH
// Register byte offsets
`define RTCA_ADDR_ALARM_WEEKDAY 12'h0_0EB
`define RTCA_ADDR_CLOCK_CONTROL 12'h0_0EC
`define RTCA_ADDR_IRQ_STATUS 12'h0_0F0
`define RTCA_ADDR_IRQ_MASK 12'h0_0F4
// Control register field positions
`define RTCA_CTL_ALARM 7
`define RTCA_CTL_INT_EN 6
`define RTCA_CTL_BCD 5
`define RTCA_CTL_CLK_SEL 4
`define RTCA_CTL_FREQ 3
`define RTCA_CTL_SLP 1
`define RTCA_CTL_UNLOCK 0
// Prescale counts
`define RTCA_DIV_XTAL 16'h8000
`define RTCA_DIV_60HZ 16'h003C
`define RTCA_DIV_50HZ 16'h0032
// Weekday legal range
`define RTCA_WDAY_MIN 4'h1
`define RTCA_WDAY_MAX 4'h7
`endif

// >>> logic/rtca_pkg.sv
// Types shared by the clock control block
// Assumes the params header is on the include path
`default_nettype none
package rtca_pkg;
  // Control register layout
  typedef struct packed {
    logic alarm;
    logic int_en;
    logic bcd;
    logic clk_sel;
    logic freq;
    logic rsvd;
    logic slp;
    logic unlock;
  } rtca_ctl_t;
  // Timing base outputs to the counter
  typedef struct packed {
    logic osc_en;
    logic sec_tick;
    logic count_en;
    logic bcd;
    logic cnt_wr_en;
  } rtca_base_t;
endpackage
`default_nettype wire

// >>> logic/rtca_ctrl.sv
// Clock control and alarm weekday registers of the real time clock
// Assumes AXI4-Lite master on aclk; time base inputs asynchronous
// Functional notes
// - Source bit picks crystal or line input
// - Crystal: oscillator on, divide by 32768
// - Line source: oscillator off, prescale by frequency
// - Frequency bit: 0 is 60Hz, 1 is 50Hz
// - Coding bit selects binary or BCD values
// - Locked: no count writes, counter runs
// - Weekday 1..7 in low nibble, upper zero
// - Weekday writable only when unlocked
// - Reset clears upper nibble, weekday kept
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "rtca_params.svh"
module rtca_ctrl
  import rtca_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic xtal_clk_in,
  input wire logic line_freq_in,
  input wire logic alarm_match,
  output rtca_base_t time_base,
  output logic sleep_recovery_reset,
  output logic irq
);

  //////////////////////////////////////////////////////////////////////
  // State
  rtca_ctl_t ctl; // Control register
  logic [3:0] alarm_weekday_value; // Weekday, not reset
  logic [3:0] wday_hi; // Reserved nibble
  logic [1:0] irq_status; // Bit0 alarm, bit1 second tick
  logic [1:0] irq_mask;
  logic aw_held, w_held; // Captured halves of a write
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [2:0] xtal_sync, line_sync; // Two stages plus edge history
  logic [15:0] prescale;
  logic sec_pulse;
  logic alarm_d;

  // Byte lane 0 write helper; only strobe bit 0 is tested
  function automatic logic lane0(input logic [3:0] strb);
    return strb[0];
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Write channel capture; either half may come first
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response; unmapped gives SLVERR
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a == `RTCA_ADDR_ALARM_WEEKDAY || a == `RTCA_ADDR_CLOCK_CONTROL ||
           a == `RTCA_ADDR_IRQ_STATUS || a == `RTCA_ADDR_IRQ_MASK;
  endfunction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(aw_addr) ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read channel; one cycle latency
  wire rd_take = s_axi_arvalid && !s_axi_rvalid;
  wire rd_ctl = rd_take && s_axi_araddr == `RTCA_ADDR_CLOCK_CONTROL;
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
      case (s_axi_araddr)
        `RTCA_ADDR_ALARM_WEEKDAY: s_axi_rdata <= {24'h00_0000, wday_hi, alarm_weekday_value};
        `RTCA_ADDR_CLOCK_CONTROL: s_axi_rdata <= {24'h00_0000, ctl};
        `RTCA_ADDR_IRQ_STATUS: s_axi_rdata <= {30'h0000_0000, irq_status};
        `RTCA_ADDR_IRQ_MASK: s_axi_rdata <= {30'h0000_0000, irq_mask};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Control register; alarm flag set wins over read clear
  wire wr_ctl = do_write && lane0(w_strb) && aw_addr == `RTCA_ADDR_CLOCK_CONTROL;
  wire alarm_rise = alarm_match && !alarm_d;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl <= 8'h00;
      alarm_d <= 1'b0;
    end else begin
      alarm_d <= alarm_match;
      if (wr_ctl) begin
        ctl.int_en <= w_data[`RTCA_CTL_INT_EN];
        ctl.bcd <= w_data[`RTCA_CTL_BCD];
        ctl.clk_sel <= w_data[`RTCA_CTL_CLK_SEL];
        ctl.freq <= w_data[`RTCA_CTL_FREQ];
        ctl.slp <= w_data[`RTCA_CTL_SLP];
        ctl.unlock <= w_data[`RTCA_CTL_UNLOCK];
      end
      if (alarm_rise) begin
        ctl.alarm <= 1'b1;
      end else if (rd_ctl) begin
        ctl.alarm <= 1'b0;
      end
    end
  end
  // Alarm edge must leave the flag up even if a read lands alongside
  alarm_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    alarm_rise |=> ctl.alarm)
    else $error("alarm flag not set");

  // Weekday register: value survives reset, writes only when unlocked
  wire wr_wday = do_write && lane0(w_strb) && aw_addr == `RTCA_ADDR_ALARM_WEEKDAY;
  wire wday_ok = w_data[3:0] >= `RTCA_WDAY_MIN && w_data[3:0] <= `RTCA_WDAY_MAX;
  always_ff @(posedge aclk) begin
    if (wr_wday && ctl.unlock && wday_ok) begin
      alarm_weekday_value <= w_data[3:0];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wday_hi <= 4'h0;
    end else begin
      wday_hi <= 4'h0;
    end
  end

  // Weekday checks; the upper nibble is judged always, the value only on a write while locked, since the value
  // itself stays unknown until software first writes it
  wday_hi_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wday_hi == 4'h0)
    else $error("weekday upper nibble nonzero");
  wday_locked_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_wday && !ctl.unlock |=> $stable(alarm_weekday_value))
    else $error("weekday changed while locked");
  reset_hi_a: assert property (@(posedge aclk)
    !aresetn |=> wday_hi == 4'h0)
    else $error("reset left nibble");

  //////////////////////////////////////////////////////////////////////
  // Input synchronisers; edge seen on stages 2 and 3 only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xtal_sync <= 3'b000;
      line_sync <= 3'b000;
    end else begin
      xtal_sync <= {xtal_sync[1:0], xtal_clk_in};
      line_sync <= {line_sync[1:0], line_freq_in};
    end
  end
  wire src_edge = ctl.clk_sel ? (line_sync[1] && !line_sync[2])
                              : (xtal_sync[1] && !xtal_sync[2]);
  wire [15:0] div_cnt = !ctl.clk_sel ? `RTCA_DIV_XTAL
                       : (ctl.freq ? `RTCA_DIV_50HZ : `RTCA_DIV_60HZ);

  // Source and divider picks
  src_pick_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctl.clk_sel && line_sync[1] && !line_sync[2] && !xtal_sync[1] |-> !src_edge)
    else $error("wrong source counted");
  xtal_div_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctl.clk_sel |-> div_cnt == `RTCA_DIV_XTAL)
    else $error("crystal prescale wrong");
  line_div_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl.clk_sel && ctl.freq |-> div_cnt == `RTCA_DIV_50HZ)
    else $error("50 Hz prescale wrong");
  div_line_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl.clk_sel && !ctl.freq |-> div_cnt == `RTCA_DIV_60HZ)
    else $error("line prescale wrong");

  // Prescaler: counts source edges, held cleared at zero while unlocked
  always_ff @(posedge aclk) begin
    if (!aresetn || ctl.unlock) begin
      prescale <= 16'h0000;
      sec_pulse <= 1'b0;
    end else begin
      sec_pulse <= 1'b0;
      if (src_edge) begin
        if (prescale >= div_cnt - 16'h0001) begin
          prescale <= 16'h0000;
          sec_pulse <= 1'b1;
        end else begin
          prescale <= prescale + 16'h0001;
        end
      end
    end
  end

  // No seconds tick may escape while the counter is held
  unlock_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl.unlock |=> !sec_pulse)
    else $error("tick while unlocked");

  //////////////////////////////////////////////////////////////////////
  // Interrupt status; set wins over write-one clear
  wire wr_st = do_write && lane0(w_strb) && aw_addr == `RTCA_ADDR_IRQ_STATUS;
  wire wr_mk = do_write && lane0(w_strb) && aw_addr == `RTCA_ADDR_IRQ_MASK;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 2'b00;
      irq_mask <= 2'b00;
    end else begin
      irq_status <= (irq_status & ~(wr_st ? w_data[1:0] : 2'b00))
                    | {sec_pulse, alarm_rise && ctl.int_en};
      if (wr_mk) begin
        irq_mask <= w_data[1:0];
      end
    end
  end

  // Outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      time_base <= '0;
      sleep_recovery_reset <= 1'b0;
      irq <= 1'b0;
    end else begin
      time_base.osc_en <= !ctl.clk_sel;
      time_base.sec_tick <= sec_pulse;
      time_base.count_en <= !ctl.unlock;
      time_base.bcd <= ctl.bcd;
      time_base.cnt_wr_en <= ctl.unlock;
      sleep_recovery_reset <= alarm_rise && ctl.slp;
      irq <= |(irq_status & irq_mask);
    end
  end

  // Output checks; registered outputs trail their control bits by one edge,
  // so each check looks back through that register stage
  osc_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 $stable(ctl.clk_sel) |=> time_base.osc_en == !$past(ctl.clk_sel, 2))
    else $error("oscillator enable wrong");
  bcd_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ctl |=> ##1 time_base.bcd == $past(w_data[`RTCA_CTL_BCD], 2))
    else $error("coding bit not applied");
  slp_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep_recovery_reset |-> $past(ctl.slp))
    else $error("stray recovery reset");
  sleep_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctl.slp |=> !sleep_recovery_reset)
    else $error("recovery reset while disabled");
  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == $past(|(irq_status & irq_mask)))
    else $error("interrupt level wrong");
endmodule
`default_nettype wire

// >>> sim/rtca_src_model.sv
// Model of the time base sources feeding the clock control block
// Assumes one bench clock; the crystal runs only while enabled
`timescale 1ns/100ps
`default_nettype none
module rtca_src_model #(
  parameter int LINE_HALF = 3
) (
  input wire logic aclk,
  input wire logic osc_en,
  output logic xtal_clk_in,
  output logic line_freq_in
);
  int cnt = 0; // Half period count of the line input
  initial begin
    xtal_clk_in = 1'b0;
    line_freq_in = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // Line input runs free; a stopped oscillator rests low, not at last level
  always @(posedge aclk) begin
    cnt <= (cnt == LINE_HALF - 1) ? 0 : cnt + 1;
    if (cnt == LINE_HALF - 1) begin
      line_freq_in <= !line_freq_in;
    end
    xtal_clk_in <= osc_en ? !xtal_clk_in : 1'b0;
  end
endmodule
`default_nettype wire

// >>> sim/rtca_ctrl_tb.sv
// Self-checking bench of the clock control block
// Assumes an AXI4-Lite master here and the source model beside it
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin errors++; $display("BAD %0t mismatch", $time); end end
module rtca_ctrl_tb
  import rtca_pkg::*;
;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0, alarm_match = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp, rs;
  logic awready, wready, bvalid, arready, rvalid, slp_rst, irq, xtal, line;
  rtca_base_t tb;
  int errors = 0, n_tests = 0, edges = 0, slp_cnt = 0, ticks = 0;
  ////////////////////////////////////////////////////////////////
  rtca_ctrl #(.ADDR_W(12)) rtca_ctrl_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .xtal_clk_in(xtal), .line_freq_in(line), .alarm_match(alarm_match),
    .time_base(tb), .sleep_recovery_reset(slp_rst), .irq(irq));
  rtca_src_model rtca_src_model_i (.aclk(aclk), .osc_en(tb.osc_en),
    .xtal_clk_in(xtal), .line_freq_in(line));
  initial forever #2.5 aclk = !aclk;
  always @(posedge line) edges++;
  always @(posedge aclk) if (slp_rst === 1'b1) slp_cnt++;
  always @(posedge aclk) if (tb.sec_tick === 1'b1) ticks++;
  ////////////////////////////////////////////////////////////////
  // Bus tasks: ready lines stay high, so no release races the next call
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bit ta, tw;
    ta = 0;
    tw = 0;
    awaddr <= a;
    awvalid <= 1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (!ta && awready) begin
        ta = 1;
        awvalid <= 0;
      end
      if (!tw && wready) begin
        tw = 1;
        wvalid <= 0;
      end
    end
    do begin
      @(posedge aclk);
    end while (bvalid !== 1'b1);
    rs = bresp;
  endtask
  // Waits as long as the slave needs; only the watchdog ends a hang
  task automatic rd_reg(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1;
    do begin
      @(posedge aclk);
    end while (arready !== 1'b1);
    arvalid <= 0;
    do begin
      @(posedge aclk);
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
  endtask
  // Counts line edges between two seconds ticks
  task automatic period(input int n);
    while (tb.sec_tick !== 1'b1) begin
      @(posedge aclk);
    end
    edges = 0;
    do begin
      @(posedge aclk);
    end while (tb.sec_tick !== 1'b1);
    `CHK(edges, n)
  endtask
  task automatic alarm_pulse;
    slp_cnt = 0;
    alarm_match <= 1;
    repeat (2) @(posedge aclk);
    alarm_match <= 0;
    repeat (4) @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_weekday;
    wr(12'h0EC, 32'h1);
    repeat (2) @(posedge aclk);
    `CHK({tb.count_en, tb.cnt_wr_en}, 2'b01)
    wr(12'h0EB, 32'h5);
    rd_reg(12'h0EB);
    `CHK(rd, 32'h0000_0005)
    wr(12'h0EB, 32'h8);
    rd_reg(12'h0EB);
    `CHK(rd, 32'h0000_0005)
    wr(12'h0EB, 32'h7);
    wr(12'h0EB, 32'h0);
    wr(12'h0EC, 32'h0);
    repeat (2) @(posedge aclk);
    `CHK({tb.count_en, tb.cnt_wr_en}, 2'b10)
    wr(12'h0EB, 32'h2);
    rd_reg(12'h0EB);
    `CHK(rd, 32'h0000_0007)
    aresetn <= 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rd_reg(12'h0EB);
    `CHK(rd, 32'h0000_0007)
    $display("test weekday done");
  endtask
  task automatic t_base;
    wr(12'h0EC, 32'h20);
    repeat (2) @(posedge aclk);
    `CHK({tb.bcd, tb.osc_en}, 2'b11)
    ticks = 0;
    repeat (400) @(posedge aclk);
    `CHK(ticks, 0)
    wr(12'h0EC, 32'h10);
    repeat (2) @(posedge aclk);
    `CHK(tb.osc_en, 1'b0)
    period(60);
    wr(12'h0EC, 32'h18);
    period(50);
    $display("test time base done");
  endtask
  task automatic t_alarm;
    rd_reg(12'h0F8);
    `CHK({rs, rd}, {2'b10, 32'h0})
    wr(12'h0F8, 32'h1);
    `CHK(rs, 2'b10)
    wr(12'h0F4, 32'h1);
    `CHK(rs, 2'b00)
    wr(12'h0EC, 32'h42);
    alarm_pulse();
    `CHK({irq, slp_cnt}, {1'b1, 32'd1})
    rd_reg(12'h0EC);
    `CHK(rd, 32'h0000_00C2)
    rd_reg(12'h0EC);
    `CHK(rd, 32'h0000_0042)
    wr(12'h0F0, 32'h1);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
    wr(12'h0EC, 32'h0);
    alarm_pulse();
    `CHK({irq, slp_cnt}, {1'b0, 32'd0})
    $display("test alarm done");
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    t_weekday();
    t_base();
    t_alarm();
    close_out();
  end
  // Watchdog well past the fewer than two thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
